// ===== rtl/iefb_gate.sv
// Gates a group of flags by enables and priority fields.
// Assumes all inputs are on one clock; the result is combinational.
`timescale 1ns/1ps
module iefb_gate #(
  parameter int N = 16
) (
  // Sources
  input wire logic [N-1:0] flags,
  input wire logic [N-1:0] enables,
  input wire logic [3*N-1:0] prios,
  // Forwarded requests
  output logic [N-1:0] req
);

  // ==========================================================
  // Per-source gate
  for (genvar i = 0; i < N; i++) begin : g_src
    assign req[i] = flags[i] & enables[i] &
                    (prios[3*i +: 3] != iefb_pkg::PRIO_OFF);
  end

endmodule

// ===== rtl/iefb_pkg.sv
// Constants for the interrupt enable and flag bank.
// Assumes a 16-bit register port and one 40 MHz system clock.
package iefb_pkg;

  // ==========================================================
  // Register port shape
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int PRIO_W = 3;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] FLAG5_OFS = 4'h0;
  localparam logic [3:0] EN0_OFS = 4'h1;
  localparam logic [3:0] EN1_OFS = 4'h2;
  localparam logic [3:0] EN2_OFS = 4'h3;

  // ==========================================================
  // Implemented-bit masks and reset values
  localparam logic [15:0] FLAG5_MASK = 16'h0040;
  localparam logic [15:0] EN0_MASK = 16'h3FEF;
  localparam logic [15:0] EN1_MASK = 16'hFE1F;
  localparam logic [15:0] EN2_MASK = 16'h22E3;
  localparam logic [15:0] FLAG5_RST = 16'h0000;
  localparam logic [15:0] EN0_RST = 16'h0000;
  localparam logic [15:0] EN1_RST = 16'h0000;
  localparam logic [15:0] EN2_RST = 16'h0000;
  localparam logic [2:0] PRIO_OFF = 3'h0;

  // ==========================================================
  // Field positions
  localparam int USB_OTG_REQUEST_FLAG = 6;
  localparam int ADC_DONE_EN = 13;
  localparam int UART_A_TX_EN = 12;
  localparam int UART_A_RX_EN = 11;
  localparam int SPI_A_DONE_EN = 10;
  localparam int SPI_A_FAULT_EN = 9;
  localparam int TIMER_THREE_EN = 8;
  localparam int TIMER_TWO_EN = 7;
  localparam int COMPARE_TWO_EN = 6;
  localparam int CAPTURE_TWO_EN = 5;
  localparam int TIMER_ONE_EN = 3;
  localparam int COMPARE_ONE_EN = 2;
  localparam int CAPTURE_ONE_EN = 1;
  localparam int EXT_IRQ_ZERO_EN = 0;
  localparam int UART_B_TX_EN = 15;
  localparam int UART_B_RX_EN = 14;
  localparam int EXT_IRQ_TWO_EN = 13;
  localparam int TIMER_FIVE_EN = 12;
  localparam int TIMER_FOUR_EN = 11;
  localparam int COMPARE_FOUR_EN = 10;
  localparam int COMPARE_THREE_EN = 9;
  localparam int EXT_IRQ_ONE_EN = 4;
  localparam int CHANGE_NOTIFY_EN = 3;
  localparam int COMPARATOR_EN = 2;
  localparam int I2C_A_MASTER_EN = 1;
  localparam int I2C_A_SLAVE_EN = 0;
  localparam int PARALLEL_PORT_EN = 13;
  localparam int COMPARE_FIVE_EN = 9;
  localparam int CAPTURE_FIVE_EN = 7;
  localparam int CAPTURE_FOUR_EN = 6;
  localparam int CAPTURE_THREE_EN = 5;
  localparam int SPI_B_EVENT_EN = 1;
  localparam int SPI_B_FAULT_EN = 0;

endpackage

// ===== rtl/iefb_reg.sv
// One software register with a mask of implemented bits.
// Assumes set requests come from logic on the same clock.
`timescale 1ns/1ps
module iefb_reg #(
  parameter logic [15:0] MASK = 16'hFFFF,
  parameter logic [15:0] RST = 16'h0000
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Software write
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // Hardware set, one bit per field
  input wire logic [15:0] set_bits,
  // Stored value
  output logic [15:0] q
);

  logic [15:0] q_r;
  logic [15:0] q_nxt;

  // ==========================================================
  // Next value
  // A hardware set is applied after the write so it is never lost.
  always_comb begin
    q_nxt = q_r;
    if (wr_en) begin
      q_nxt = wr_data & MASK;
    end
    q_nxt = q_nxt | (set_bits & MASK);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      q_r <= RST & MASK;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// ===== rtl/iefb_top.sv
// Interrupt enable and flag bank: the fifth flag register and three
// enable registers, with request gating toward priority resolution.
// Assumes a same-clock register port, flag inputs from the other flag
// registers and priority fields from the priority registers.
//
// Summary of operation
// - Flag register five holds only bit 6, the USB request flag.
// - Unimplemented bits ignore writes and read as zero.
// - An enable bit of 1 passes its source request, 0 blocks it.
// - Implemented bits are read/write and clear at reset.
// - Enable zero upper byte: ADC, UART A tx/rx, SPI A, timer three.
// - Enable zero lower byte: timers, compares, captures, external zero.
// - Enable one: UART B, externals, timers, compares, notify, I2C A.
// - Enable two: parallel port, compare five, captures, SPI B.
// - Priority field 000 disables the source; 111 is highest.
`timescale 1ns/1ps
module iefb_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Event and flag inputs
  input wire logic usb_otg_event,
  input wire logic [15:0] flag0_in,
  input wire logic [15:0] flag1_in,
  input wire logic [15:0] flag2_in,
  input wire logic usb_en_in,
  // Priority fields, three bits per bit position
  input wire logic [47:0] prio0_in,
  input wire logic [47:0] prio1_in,
  input wire logic [47:0] prio2_in,
  input wire logic [2:0] usb_prio_in,
  // Requests toward priority resolution
  output logic [15:0] irq_req0,
  output logic [15:0] irq_req1,
  output logic [15:0] irq_req2,
  output logic usb_req
);

  // ==========================================================
  // Address decode
  logic wr_flag5;
  logic wr_en0;
  logic wr_en1;
  logic wr_en2;
  logic [15:0] usb_set;

  always_comb begin
    wr_flag5 = reg_wr && (reg_addr == iefb_pkg::FLAG5_OFS);
    wr_en0 = reg_wr && (reg_addr == iefb_pkg::EN0_OFS);
    wr_en1 = reg_wr && (reg_addr == iefb_pkg::EN1_OFS);
    wr_en2 = reg_wr && (reg_addr == iefb_pkg::EN2_OFS);
    usb_set = 16'h0000;
    usb_set[iefb_pkg::USB_OTG_REQUEST_FLAG] = usb_otg_event;
  end

  // ==========================================================
  // Registers
  logic [15:0] flag5_q;
  logic [15:0] en0_q;
  logic [15:0] en1_q;
  logic [15:0] en2_q;

  // A flag stays set until software writes a 0 over it.
  iefb_reg #(
    .MASK(iefb_pkg::FLAG5_MASK),
    .RST(iefb_pkg::FLAG5_RST)
  ) u_flag5 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr_en(wr_flag5),
    .wr_data(reg_wdata),
    .set_bits(usb_set),
    .q(flag5_q)
  );

  iefb_reg #(
    .MASK(iefb_pkg::EN0_MASK),
    .RST(iefb_pkg::EN0_RST)
  ) u_en0 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr_en(wr_en0),
    .wr_data(reg_wdata),
    .set_bits(16'h0000),
    .q(en0_q)
  );

  iefb_reg #(
    .MASK(iefb_pkg::EN1_MASK),
    .RST(iefb_pkg::EN1_RST)
  ) u_en1 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr_en(wr_en1),
    .wr_data(reg_wdata),
    .set_bits(16'h0000),
    .q(en1_q)
  );

  iefb_reg #(
    .MASK(iefb_pkg::EN2_MASK),
    .RST(iefb_pkg::EN2_RST)
  ) u_en2 (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr_en(wr_en2),
    .wr_data(reg_wdata),
    .set_bits(16'h0000),
    .q(en2_q)
  );

  // ==========================================================
  // Request gating
  // External inputs only carry events once pin selection routes them.
  logic [15:0] gate0;
  logic [15:0] gate1;
  logic [15:0] gate2;
  logic gate_usb;
  logic [15:0] flag0_m;
  logic [15:0] flag1_m;
  logic [15:0] flag2_m;

  assign flag0_m = flag0_in & iefb_pkg::EN0_MASK;
  assign flag1_m = flag1_in & iefb_pkg::EN1_MASK;
  assign flag2_m = flag2_in & iefb_pkg::EN2_MASK;

  iefb_gate #(.N(16)) u_gate0 (
    .flags(flag0_m),
    .enables(en0_q),
    .prios(prio0_in),
    .req(gate0)
  );

  iefb_gate #(.N(16)) u_gate1 (
    .flags(flag1_m),
    .enables(en1_q),
    .prios(prio1_in),
    .req(gate1)
  );

  iefb_gate #(.N(16)) u_gate2 (
    .flags(flag2_m),
    .enables(en2_q),
    .prios(prio2_in),
    .req(gate2)
  );

  iefb_gate #(.N(1)) u_gate_usb (
    .flags(flag5_q[iefb_pkg::USB_OTG_REQUEST_FLAG]),
    .enables(usb_en_in),
    .prios(usb_prio_in),
    .req(gate_usb)
  );

  logic [15:0] irq_req0_r;
  logic [15:0] irq_req1_r;
  logic [15:0] irq_req2_r;
  logic usb_req_r;
  logic [15:0] irq_req0_nxt;
  logic [15:0] irq_req1_nxt;
  logic [15:0] irq_req2_nxt;
  logic usb_req_nxt;

  always_comb begin
    irq_req0_nxt = gate0;
    irq_req1_nxt = gate1;
    irq_req2_nxt = gate2;
    usb_req_nxt = gate_usb;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_req0_r <= 16'h0000;
      irq_req1_r <= 16'h0000;
      irq_req2_r <= 16'h0000;
      usb_req_r <= 1'b0;
    end else begin
      irq_req0_r <= irq_req0_nxt;
      irq_req1_r <= irq_req1_nxt;
      irq_req2_r <= irq_req2_nxt;
      usb_req_r <= usb_req_nxt;
    end
  end

  assign irq_req0 = irq_req0_r;
  assign irq_req1 = irq_req1_r;
  assign irq_req2 = irq_req2_r;
  assign usb_req = usb_req_r;

  // ==========================================================
  // Read port
  // Data stand only in the cycle after the strobe, zero otherwise.
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  always_comb begin
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        iefb_pkg::FLAG5_OFS: rdata_nxt = flag5_q;
        iefb_pkg::EN0_OFS: rdata_nxt = en0_q;
        iefb_pkg::EN1_OFS: rdata_nxt = en1_q;
        iefb_pkg::EN2_OFS: rdata_nxt = en2_q;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================
  // Assertions
  logic [15:0] rd_mask_r;
  logic [15:0] rd_mask_nxt;

  always_comb begin
    rd_mask_nxt = 16'h0000;
    unique case (reg_addr)
      iefb_pkg::FLAG5_OFS: rd_mask_nxt = iefb_pkg::FLAG5_MASK;
      iefb_pkg::EN0_OFS: rd_mask_nxt = iefb_pkg::EN0_MASK;
      iefb_pkg::EN1_OFS: rd_mask_nxt = iefb_pkg::EN1_MASK;
      iefb_pkg::EN2_OFS: rd_mask_nxt = iefb_pkg::EN2_MASK;
      default: rd_mask_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_mask_r <= 16'h0000;
    end else begin
      rd_mask_r <= rd_mask_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_usb_req;
    (flag5_q[iefb_pkg::USB_OTG_REQUEST_FLAG] && usb_en_in &&
     usb_prio_in != iefb_pkg::PRIO_OFF) |=> usb_req;
  endproperty
  a_usb_req: assert property (p_usb_req)
    else $error("Flagged and enabled USB source not forwarded");

  property p_usb_flag;
    usb_otg_event |=> flag5_q == 16'h0040;
  endproperty
  a_usb_flag: assert property (p_usb_flag)
    else $error("USB event did not set the flag bit alone");

  property p_set_wins;
    (usb_otg_event && wr_flag5 && reg_wdata == 16'h0000)
      |=> flag5_q[iefb_pkg::USB_OTG_REQUEST_FLAG];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Clear beat a simultaneous USB event");

  property p_unimpl_zero;
    reg_rd |=> (reg_rdata & ~rd_mask_r) == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("Unimplemented bit read as one");

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("Read data present without a read strobe");

  property p_en0_write;
    wr_en0 |=> en0_q == ($past(reg_wdata) & 16'h3FEF);
  endproperty
  a_en0_write: assert property (p_en0_write)
    else $error("Enable zero write stored wrong bits");

  property p_en0_lower;
    (wr_en0 && reg_wdata == 16'hFFFF) |=>
      (en0_q[7:0] == 8'hEF) ##1 (irq_req0[4] == 1'b0);
  endproperty
  a_en0_lower: assert property (p_en0_lower)
    else $error("Enable zero lower byte layout wrong");

  property p_en1_write;
    wr_en1 |=> en1_q == ($past(reg_wdata) & 16'hFE1F);
  endproperty
  a_en1_write: assert property (p_en1_write)
    else $error("Enable one write stored wrong bits");

  property p_en2_write;
    wr_en2 |=> en2_q == ($past(reg_wdata) & 16'h22E3);
  endproperty
  a_en2_write: assert property (p_en2_write)
    else $error("Enable two write stored wrong bits");

  property p_blocked;
    (en1_q[iefb_pkg::TIMER_FOUR_EN] == 1'b0)
      |=> !irq_req1[iefb_pkg::TIMER_FOUR_EN];
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("Disabled source still requested");

  property p_prio_off;
    (usb_prio_in == 3'h0) |=> !usb_req;
  endproperty
  a_prio_off: assert property (p_prio_off)
    else $error("Priority zero source still requested");

  property p_forward;
    (flag0_in[iefb_pkg::TIMER_ONE_EN] && en0_q[iefb_pkg::TIMER_ONE_EN] &&
     prio0_in[11:9] == 3'h7) |=> irq_req0[iefb_pkg::TIMER_ONE_EN];
  endproperty
  a_forward: assert property (p_forward)
    else $error("Flagged and enabled source not forwarded");

  property p_flag_hold;
    (flag5_q[iefb_pkg::USB_OTG_REQUEST_FLAG] && !wr_flag5)
      |=> flag5_q[iefb_pkg::USB_OTG_REQUEST_FLAG];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("USB flag dropped without a write");

  property p_cv_usb_req;
    usb_otg_event ##1 1'b1 ##1 usb_req;
  endproperty
  c_usb_req: cover property (p_cv_usb_req);

  property p_cv_en_rd;
    wr_en2 ##1 (reg_rd && reg_addr == iefb_pkg::EN2_OFS);
  endproperty
  c_en_rd: cover property (p_cv_en_rd);

  property p_cv_clash;
    usb_otg_event && wr_flag5;
  endproperty
  c_clash: cover property (p_cv_clash);

  property p_cv_unmapped;
    reg_rd && reg_addr == 4'hF;
  endproperty
  c_unmapped: cover property (p_cv_unmapped);

endmodule

// ===== tb/iefb_src_model.sv
// Model of the peripheral sources and the priority fields.
// Assumes one clock; the bench gives its commands on rising edges.
`timescale 1ns/1ps
module iefb_src_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Commands from the bench
  input wire logic [47:0] flags_cmd,
  input wire logic [2:0] prio_lvl,
  input wire logic ext_routed,
  input wire logic usb_fire,
  // Toward the bank
  output logic [15:0] flag0_in,
  output logic [15:0] flag1_in,
  output logic [15:0] flag2_in,
  output logic [47:0] prio0_in,
  output logic [47:0] prio1_in,
  output logic [47:0] prio2_in,
  output logic [2:0] usb_prio_in,
  output logic usb_otg_event
);
  logic [47:0] flags_r;
  logic [47:0] flags_nxt;
  logic usb_r;
  logic usb_nxt;

  // ==========================================================
  // Flag sources
  // An external line that is not routed to a pin never sees an edge,
  // so its flag cannot rise however software sets its enable.
  always_comb begin
    flags_nxt = flags_cmd;
    usb_nxt = usb_fire;
    if (!ext_routed) begin
      flags_nxt[0] = 1'b0;
      flags_nxt[20] = 1'b0;
      flags_nxt[29] = 1'b0;
    end
    if (!rst_b) begin
      flags_nxt = 48'h0;
      usb_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    flags_r <= flags_nxt;
    usb_r <= usb_nxt;
  end

  assign flag0_in = flags_r[15:0];
  assign flag1_in = flags_r[31:16];
  assign flag2_in = flags_r[47:32];
  assign usb_otg_event = usb_r;
  assign prio0_in = {16{prio_lvl}};
  assign prio1_in = {16{prio_lvl}};
  assign prio2_in = {16{prio_lvl}};
  assign usb_prio_in = prio_lvl;
endmodule

// ===== tb/iefb_top_tb.sv
// Self-checking bench for the interrupt enable and flag bank.
// Assumes the source model drives flags one cycle late and priorities at once.
`timescale 1ns/1ps
module iefb_top_tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic usb_otg_event;
  logic [15:0] flag0_in, flag1_in, flag2_in;
  logic usb_en_in = 1'b0;
  logic [47:0] prio0_in, prio1_in, prio2_in;
  logic [2:0] usb_prio_in;
  logic [15:0] irq_req0, irq_req1, irq_req2;
  logic usb_req;
  logic [47:0] flags_cmd = 48'h0;
  logic [2:0] prio_lvl = 3'h0;
  logic ext_routed = 1'b0;
  logic usb_fire = 1'b0;
  int mismatches = 0;
  int n_compared = 0;
  // Rows: address, write data, value read back.
  logic [35:0] rows [10] = '{
    {4'h0, 16'hFFFF, 16'h0040}, {4'h0, 16'h0000, 16'h0000},
    {4'h1, 16'hFFFF, 16'h3FEF}, {4'h1, 16'h5555, 16'h1545},
    {4'h2, 16'hFFFF, 16'hFE1F}, {4'h2, 16'hAAAA, 16'hAA0A},
    {4'h3, 16'hFFFF, 16'h22E3}, {4'h3, 16'h5555, 16'h0041},
    {4'h4, 16'hFFFF, 16'h0000}, {4'hF, 16'hFFFF, 16'h0000}};

  iefb_top iefb_top_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .usb_otg_event(usb_otg_event), .flag0_in(flag0_in),
    .flag1_in(flag1_in), .flag2_in(flag2_in), .usb_en_in(usb_en_in),
    .prio0_in(prio0_in), .prio1_in(prio1_in), .prio2_in(prio2_in),
    .usb_prio_in(usb_prio_in), .irq_req0(irq_req0), .irq_req1(irq_req1),
    .irq_req2(irq_req2), .usb_req(usb_req));

  iefb_src_model iefb_src_model_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .flags_cmd(flags_cmd), .prio_lvl(prio_lvl), .ext_routed(ext_routed),
    .usb_fire(usb_fire), .flag0_in(flag0_in), .flag1_in(flag1_in),
    .flag2_in(flag2_in), .prio0_in(prio0_in), .prio1_in(prio1_in),
    .prio2_in(prio2_in), .usb_prio_in(usb_prio_in),
    .usb_otg_event(usb_otg_event));

  // ==========================================================
  // Clock, verdict and watchdog
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #200us;
    mismatches++;
    summarize();
  end

  // ==========================================================
  // Bus tasks and comparison
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
    @(posedge ref_clk);
  endtask

  // Requests settle two edges after a command: model, then bank.
  // Returns on a rising edge so that the next stimulus lands there.
  task automatic req_chk(logic [15:0] e0, logic [15:0] e1,
                         logic [15:0] e2, logic eu);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("irq_req0", e0, irq_req0);
    chk("irq_req1", e1, irq_req1);
    chk("irq_req2", e2, irq_req2);
    chk("usb_req", {15'h0, eu}, {15'h0, usb_req});
    @(posedge ref_clk);
  endtask

  // ==========================================================
  // Sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(a[3:0], 16'h0000);
    end
    req_chk(16'h0, 16'h0, 16'h0, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i][35:32], rows[i][31:16]);
      rd(rows[i][35:32], rows[i][15:0]);
    end
    // Unmapped writes above must not have disturbed enable zero.
    rd(iefb_pkg::EN0_OFS, 16'h1545);
    @(posedge ref_clk);
    #1;
    chk("reg_rdata idle", 16'h0000, reg_rdata);
    // Write then read the same register with no gap.
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= iefb_pkg::EN2_OFS;
    reg_wdata <= 16'hFFFF;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata b2b", iefb_pkg::EN2_MASK, reg_rdata);
    // Gating of the bank sources by enables zero and one, priority and routing.
    wr(iefb_pkg::EN0_OFS, 16'hFFFF);
    wr(iefb_pkg::EN1_OFS, 16'hFFFF);
    flags_cmd <= {48{1'b1}};
    prio_lvl <= 3'h7;
    ext_routed <= 1'b1;
    req_chk(iefb_pkg::EN0_MASK, iefb_pkg::EN1_MASK,
            iefb_pkg::EN2_MASK, 1'b0);
    ext_routed <= 1'b0;
    req_chk(16'h3FEE, 16'hDE0F, iefb_pkg::EN2_MASK, 1'b0);
    ext_routed <= 1'b1;
    prio_lvl <= 3'h0;
    req_chk(16'h0, 16'h0, 16'h0, 1'b0);
    prio_lvl <= 3'h1;
    flags_cmd <= 48'h00FF_00FF_00FF;
    wr(iefb_pkg::EN0_OFS, 16'h5555);
    req_chk(16'h0045, 16'h001F, 16'h00E3, 1'b0);
    wr(iefb_pkg::EN1_OFS, 16'h0000);
    req_chk(16'h0045, 16'h0000, 16'h00E3, 1'b0);
    // USB request: set by event, held until software clears it.
    usb_en_in <= 1'b1;
    @(posedge ref_clk);
    usb_fire <= 1'b1;
    @(posedge ref_clk);
    usb_fire <= 1'b0;
    req_chk(16'h0045, 16'h0000, 16'h00E3, 1'b1);
    rd(iefb_pkg::FLAG5_OFS, iefb_pkg::FLAG5_MASK);
    usb_en_in <= 1'b0;
    req_chk(16'h0045, 16'h0000, 16'h00E3, 1'b0);
    usb_en_in <= 1'b1;
    req_chk(16'h0045, 16'h0000, 16'h00E3, 1'b1);
    wr(iefb_pkg::FLAG5_OFS, 16'h0000);
    rd(iefb_pkg::FLAG5_OFS, 16'h0000);
    req_chk(16'h0045, 16'h0000, 16'h00E3, 1'b0);
    // Event and software clear land on the same edge: the set wins.
    usb_fire <= 1'b1;
    @(posedge ref_clk);
    usb_fire <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= iefb_pkg::FLAG5_OFS;
    reg_wdata <= 16'h0000;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    rd(iefb_pkg::FLAG5_OFS, iefb_pkg::FLAG5_MASK);
    // A second reset mid-run clears everything again.
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    flags_cmd <= 48'h0;
    for (int a = 0; a < 4; a++) begin
      rd(a[3:0], 16'h0000);
    end
    req_chk(16'h0, 16'h0, 16'h0, 1'b0);
    summarize();
  end
endmodule
